// file: pkg/ccps_pkg.sv
// Shared constants, comparator bundle, state types for the charge sequencer.
// Assumes a single 10 MHz clock; all comparator levels arrive asynchronously.
package ccps_pkg;

   // Clock and tick base
   localparam int CLK_PERIOD_NS   = 100;
   localparam int TICK_PERIOD_NS  = 100000;
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICKS_PER_S     = 1000000000 / TICK_PERIOD_NS;

   // Times as printed, then derived counts
   localparam int DEAD_TIME_NS    = 10000;
   localparam int DEAD_CYCLES     = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STARTUP_MS      = 30;
   localparam int STARTUP_TICKS   = STARTUP_MS * 1000000 / TICK_PERIOD_NS;
   localparam int STEP_US         = 1600;
   localparam int STEP_TICKS      = STEP_US * 1000 / TICK_PERIOD_NS;
   localparam int SS_STEPS        = 8;
   localparam int PRECHG_MIN      = 30;
   localparam int PRECHG_TICKS_DEF = PRECHG_MIN * 60 * TICKS_PER_S;
   localparam int K_TIMER_DECIMIN_PER_NF = 56;
   localparam int SAFETY_TICKS_NF_DEF = K_TIMER_DECIMIN_PER_NF * 6 * TICKS_PER_S;
   localparam int FILT_LEN        = 3;

   localparam logic [8:0] STARTUP_LAST = 9'(STARTUP_TICKS - 1);
   localparam logic [8:0] DEAD_LAST    = 9'(DEAD_CYCLES - 1);
   localparam logic [4:0] STEP_LAST    = 5'(STEP_TICKS - 1);
   localparam logic [3:0] STEP_TOP     = 4'(SS_STEPS);

   // Register map
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_TCAP  = 8'h04;
   localparam logic [7:0] REG_STAT  = 8'h08;
   localparam logic [6:0] TCAP_RESET = 7'h0a;

   typedef struct packed {
      logic batt_below_precharge;
      logic fb_above_recharge;
      logic cur_below_term;
      logic cv_phase;
      logic batt_below_recharge;
      logic supply_above_sense;
      logic supply_near_sense;
      logic undervoltage_lockout;
      logic supply_low_state;
      logic input_overvoltage;
      logic driver_regulator_good;
      logic driver_regulator_overload;
      logic die_overtemp_shutdown;
      logic pack_temp_fault;
      logic battery_overvoltage;
      logic charge_allow;
      logic timer_program_pin_low;
      logic timer_program_pin_ref;
   } ccps_cmp_t;

   localparam int CMP_W = $bits(ccps_cmp_t);

   typedef enum logic [4:0] {
      CHG_IDLE = 5'h01, CHG_PRE = 5'h02, CHG_FAST = 5'h04, CHG_DONE = 5'h08, CHG_FAULT = 5'h10
   } ccps_chg_t;

   typedef enum logic [4:0] {
      PWR_BATT = 5'h01, PWR_WAIT = 5'h02, PWR_TO_AC = 5'h04, PWR_AC = 5'h08, PWR_TO_BAT = 5'h10
   } ccps_pwr_t;

   typedef struct packed {
      ccps_chg_t   chg;
      ccps_pwr_t   pwr;
      ccps_cmp_t   prev;
      logic [8:0]  por_cnt;
      logic        por_done;
      logic [8:0]  pwr_cnt;
      logic [24:0] pre_cnt;
      logic [29:0] safe_cnt;
      logic [3:0]  step;
      logic [4:0]  step_cnt;
      logic        fault;
      logic        inhibit;
      logic [6:0]  cap;
      logic        ac_on;
      logic        bat_on;
      logic        chg_on;
      logic        pre_sel;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } ccps_state_t;

endpackage

// file: hw/ccps_tick.sv
// Divider giving a one-cycle enable pulse every TICK_CYCLES clocks.
// Assumes pclk only; the pulse is the slow time base of the sequencer.
`timescale 1ns/1ns
module ccps_tick
   import ccps_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } ccps_tick_t;

   ccps_tick_t t_reg;
   ccps_tick_t t_next;

   always_comb begin
      t_next = t_reg;
      t_next.tick = 1'b0;
      if (t_reg.cnt == 16'(TICK_CYCLES - 1)) begin
         t_next.cnt  = 16'h0000;
         t_next.tick = 1'b1;
      end else begin
         t_next.cnt = t_reg.cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   assign tick = t_reg.tick;
endmodule // ccps_tick

// file: hw/ccps_sync_filt.sv
// Two-flop synchroniser plus glitch filter for each comparator level.
// Assumes inputs are asynchronous; output changes after FILT_LEN equal samples.
`timescale 1ns/1ns
module ccps_sync_filt
   import ccps_pkg::*;
#(
   parameter int W = CMP_W
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d_async,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0]               s1;
      logic [W-1:0]               s2;
      logic [FILT_LEN-1:0][W-1:0] h;
      logic [W-1:0]               q;
   } ccps_flt_t;

   ccps_flt_t    f_reg;
   ccps_flt_t    f_next;
   logic [W-1:0] q_nx;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic all_hi;
         logic all_lo;
         always_comb begin
            all_hi = 1'b1;
            all_lo = 1'b1;
            for (int k = 0; k < FILT_LEN; k++) begin
               all_hi = all_hi & f_reg.h[k][i];
               all_lo = all_lo & ~f_reg.h[k][i];
            end
         end
         assign q_nx[i] = all_hi ? 1'b1 : (all_lo ? 1'b0 : f_reg.q[i]);
      end
   endgenerate

   always_comb begin
      f_next    = f_reg;
      f_next.s1 = d_async;
      f_next.s2 = f_reg.s1;
      f_next.h  = {f_reg.h[FILT_LEN-2:0], f_reg.s2};
      f_next.q  = q_nx;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   assign q = f_reg.q;
endmodule // ccps_sync_filt

// file: hw/ccps_top.sv
// Charge phase sequencer and power-path selector with an APB register slave.
// Assumes pclk at 10 MHz, presetn is the power-on reset, comparators async.
`timescale 1ns/1ns
module ccps_top
   import ccps_pkg::*;
#(
   parameter int TICK_CYCLES         = TICK_CYCLES_DEF,
   parameter int PRECHG_TICKS        = PRECHG_TICKS_DEF,
   parameter int SAFETY_TICKS_PER_NF = SAFETY_TICKS_NF_DEF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire ccps_cmp_t   cmp_async,
   output logic             adapter_gate_drive,
   output logic             battery_gate_drive,
   output logic             charge_run,
   output logic             precharge_current_set,
   output logic      [3:0]  current_step,
   output logic             status_fault,
   output logic             status_done
);
   ccps_state_t s_reg;
   ccps_state_t s_next;
   ccps_cmp_t   c;
   logic        tick;
   logic        sleep;
   logic        prev_sleep;
   logic        adapter_ok;
   logic        en_ok;
   logic        stop;
   logic        term_en;
   logic        timer_en;
   logic        recover;
   logic        restart;
   logic        safe_exp;
   logic        charging;
   logic        term_hit;
   logic [29:0] safe_target;
   logic        acc;

   ccps_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   ccps_sync_filt #(
      .W (CMP_W)
   ) u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .d_async (cmp_async),
      .q       (c)
   );

   // Condition decoding
   always_comb begin
      sleep       = ~c.supply_above_sense;
      prev_sleep  = ~s_reg.prev.supply_above_sense;
      adapter_ok  = ~sleep & ~c.undervoltage_lockout & ~c.input_overvoltage;
      term_en     = ~c.timer_program_pin_low;
      timer_en    = ~c.timer_program_pin_low & ~c.timer_program_pin_ref;
      en_ok = c.charge_allow & ~c.undervoltage_lockout & ~c.supply_low_state & ~sleep
            & ~c.input_overvoltage & s_reg.por_done & c.driver_regulator_good
            & ~c.die_overtemp_shutdown & ~c.pack_temp_fault & ~s_reg.inhibit
            & (s_reg.pwr == PWR_AC);
      safe_target = 30'(s_reg.cap) * 30'(SAFETY_TICKS_PER_NF);
      safe_exp    = timer_en & (s_reg.safe_cnt >= safe_target);
      stop        = ~en_ok | c.driver_regulator_overload | safe_exp;
      recover = (s_reg.prev.input_overvoltage & ~c.input_overvoltage)
              | (s_reg.prev.supply_low_state & ~c.supply_low_state)
              | (prev_sleep & ~sleep);
      restart = (c.charge_allow != s_reg.prev.charge_allow)
              | ((s_reg.chg == CHG_DONE) & c.batt_below_recharge);
      charging = (s_reg.chg == CHG_PRE) | (s_reg.chg == CHG_FAST);
      term_hit = c.cv_phase & term_en & c.fb_above_recharge & c.cur_below_term;
      acc      = psel & penable;
   end

   always_comb begin
      s_next      = s_reg;
      s_next.prev = c;

      // Power-up delay
      if (tick && !s_reg.por_done) begin
         s_next.por_cnt = s_reg.por_cnt + 9'h001;
         if (s_reg.por_cnt == STARTUP_LAST) begin
            s_next.por_done = 1'b1;
         end
      end

      // Power path selector
      if (c.undervoltage_lockout) begin
         s_next.pwr     = PWR_BATT;
         s_next.pwr_cnt = 9'h000;
      end else begin
         case (s_reg.pwr)
            PWR_BATT: begin
               if (adapter_ok) begin
                  s_next.pwr     = PWR_WAIT;
                  s_next.pwr_cnt = 9'h000;
               end
            end
            PWR_WAIT: begin
               if (!adapter_ok) begin
                  s_next.pwr = PWR_BATT;
               end else if (tick) begin
                  s_next.pwr_cnt = s_reg.pwr_cnt + 9'h001;
                  if (s_reg.pwr_cnt == STARTUP_LAST) begin
                     s_next.pwr     = PWR_TO_AC;
                     s_next.pwr_cnt = 9'h000;
                  end
               end
            end
            PWR_TO_AC: begin
               if (!adapter_ok) begin
                  s_next.pwr = PWR_BATT;
               end else begin
                  s_next.pwr_cnt = s_reg.pwr_cnt + 9'h001;
                  if (s_reg.pwr_cnt == DEAD_LAST) begin
                     s_next.pwr = PWR_AC;
                  end
               end
            end
            PWR_AC: begin
               if (c.input_overvoltage || sleep || c.supply_near_sense) begin
                  s_next.pwr     = PWR_TO_BAT;
                  s_next.pwr_cnt = 9'h000;
               end
            end
            PWR_TO_BAT: begin
               s_next.pwr_cnt = s_reg.pwr_cnt + 9'h001;
               if (s_reg.pwr_cnt == DEAD_LAST) begin
                  s_next.pwr = PWR_BATT;
               end
            end
            default: begin
               s_next.pwr = PWR_BATT;
            end
         endcase
      end
      s_next.ac_on  = (s_next.pwr == PWR_AC);
      // Battery keeps the load through the 30 ms wait; hand-over starts at the dead gap
      s_next.bat_on = (s_next.pwr == PWR_BATT) || (s_next.pwr == PWR_WAIT);

      // Safety timer
      if (restart || recover || !timer_en) begin
         s_next.safe_cnt = 30'h0;
      end else if (tick && charging && !c.battery_overvoltage && !safe_exp) begin
         s_next.safe_cnt = s_reg.safe_cnt + 30'h1;
      end

      // Charge phases
      if (restart) begin
         s_next.chg     = CHG_IDLE;
         s_next.fault   = 1'b0;
         s_next.pre_cnt = 25'h0;
         s_next.step    = 4'h0;
      end else begin
         case (s_reg.chg)
            CHG_IDLE: begin
               if (en_ok && !c.driver_regulator_overload) begin
                  if (c.batt_below_precharge) begin
                     s_next.chg     = CHG_PRE;
                     s_next.pre_cnt = 25'h0;
                  end else begin
                     s_next.chg      = CHG_FAST;
                     s_next.step     = 4'h1;
                     s_next.step_cnt = 5'h00;
                  end
               end
            end
            CHG_PRE: begin
               if (safe_exp) begin
                  s_next.chg   = CHG_FAULT;
                  s_next.fault = 1'b1;
               end else if (stop) begin
                  s_next.chg = CHG_IDLE;
               end else if (!c.batt_below_precharge) begin
                  s_next.chg      = CHG_FAST;
                  s_next.step     = 4'h1;
                  s_next.step_cnt = 5'h00;
               end else if (tick) begin
                  s_next.pre_cnt = s_reg.pre_cnt + 25'h1;
                  if (s_reg.pre_cnt == 25'(PRECHG_TICKS - 1)) begin
                     s_next.chg   = CHG_FAULT;
                     s_next.fault = 1'b1;
                  end
               end
            end
            CHG_FAST: begin
               if (safe_exp) begin
                  s_next.chg   = CHG_FAULT;
                  s_next.fault = 1'b1;
                  s_next.step  = 4'h0;
               end else if (stop) begin
                  s_next.chg  = CHG_IDLE;
                  s_next.step = 4'h0;
               end else if (term_hit) begin
                  s_next.chg  = CHG_DONE;
                  s_next.step = 4'h0;
               end else if (tick && s_reg.step != STEP_TOP) begin
                  s_next.step_cnt = s_reg.step_cnt + 5'h01;
                  if (s_reg.step_cnt == STEP_LAST) begin
                     s_next.step     = s_reg.step + 4'h1;
                     s_next.step_cnt = 5'h00;
                  end
               end
            end
            CHG_DONE: begin
               s_next.chg = CHG_DONE;
            end
            CHG_FAULT: begin
               s_next.chg = CHG_FAULT;
            end
            default: begin
               s_next.chg = CHG_IDLE;
            end
         endcase
      end
      s_next.chg_on  = (s_next.chg == CHG_PRE) || (s_next.chg == CHG_FAST);
      s_next.pre_sel = (s_next.chg == CHG_PRE);

      // APB slave: one wait state, write commits at the completing edge
      s_next.pready  = acc & ~s_reg.pready;
      s_next.pslverr = 1'b0;
      s_next.prdata  = 32'h0;
      if (acc && !s_reg.pready) begin
         if (paddr == REG_CTRL) begin
            s_next.prdata = {31'h0, s_reg.inhibit};
         end else if (paddr == REG_TCAP) begin
            s_next.prdata = {25'h0, s_reg.cap};
         end else if (paddr == REG_STAT) begin
            s_next.prdata = {14'h0, s_reg.bat_on, s_reg.ac_on, s_reg.por_done,
                             s_reg.fault, s_reg.step, s_reg.pwr, s_reg.chg};
            s_next.pslverr = pwrite;
         end else begin
            s_next.pslverr = 1'b1;
         end
         if (pwrite) begin
            s_next.prdata = 32'h0;
         end
      end
      if (acc && s_reg.pready && pwrite) begin
         if (paddr == REG_CTRL) begin
            s_next.inhibit = pwdata[0];
         end else if (paddr == REG_TCAP) begin
            s_next.cap = pwdata[6:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg          <= '0;
         s_reg.chg      <= CHG_IDLE;
         s_reg.pwr      <= PWR_BATT;
         s_reg.bat_on   <= 1'b1;
         s_reg.cap      <= TCAP_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata                = s_reg.prdata;
   assign pready                = s_reg.pready;
   assign pslverr               = s_reg.pslverr;
   assign adapter_gate_drive    = s_reg.ac_on;
   assign battery_gate_drive    = s_reg.bat_on;
   assign charge_run            = s_reg.chg_on;
   assign precharge_current_set = s_reg.pre_sel;
   assign current_step          = s_reg.step;
   assign status_fault          = s_reg.fault;
   assign status_done           = s_reg.chg[3]; // One-hot bit of CHG_DONE

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_both_off;
      !adapter_gate_drive && !battery_gate_drive;
   endsequence

   a_lockout_path: assert property (
      c.undervoltage_lockout |=> battery_gate_drive && !adapter_gate_drive)
      else $error("lockout did not select battery");
   a_dead_gap: assert property (
      $rose(adapter_gate_drive) |-> $past(!adapter_gate_drive && !battery_gate_drive, 1)
      && $past(!adapter_gate_drive && !battery_gate_drive, 90))
      else $error("adapter switch on without dead time");
   a_no_overlap: assert property (
      $fell(adapter_gate_drive) && !$past(c.undervoltage_lockout) |-> s_both_off [*8])
      else $error("battery switch on too soon after adapter");
   a_wait_battery: assert property (
      s_reg.pwr == PWR_WAIT |-> battery_gate_drive && !adapter_gate_drive)
      else $error("battery switch dropped before adapter hand-over");
   a_sleep_path: assert property (
      sleep |=> !adapter_gate_drive)
      else $error("adapter switch on while sleeping");
   a_stop_charge: assert property (
      !en_ok && !restart |=> !charge_run)
      else $error("charging despite stop condition");
   a_fault_latch: assert property (
      status_fault && !restart |=> status_fault)
      else $error("fault dropped without restart");
   a_timer_hold: assert property (
      c.timer_program_pin_low |=> s_reg.safe_cnt == 30'h0)
      else $error("safety timer not held with timer pin low");
   a_bovp_pause: assert property (
      c.battery_overvoltage && !restart && !recover && timer_en |=> $stable(s_reg.safe_cnt))
      else $error("safety timer ran during battery overvoltage");
   a_ramp_start: assert property (
      $rose(s_reg.chg == CHG_FAST) |-> current_step == 4'h1)
      else $error("fast charge did not start at first step");
   a_term_done: assert property (
      (s_reg.chg == CHG_FAST) && term_hit && !stop && !restart |=> status_done)
      else $error("termination not declared");
endmodule // ccps_top

// file: test/ccps_far_side.sv
// Far-side model: comparator levels, supply decay after unplug, switch overlap.
// Assumes the bench sets wanted levels; supply_above_sense there means plugged.
`timescale 1ns/1ns
module ccps_far_side
   import ccps_pkg::*;
#(
   parameter int DECAY = 30
) (
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire ccps_cmp_t want,
   input  wire logic      adapter_gate_drive,
   input  wire logic      battery_gate_drive,
   output ccps_cmp_t      cmp_async,
   output logic           shoot
);
   logic [7:0] decay_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decay_reg <= 8'hff;
         shoot <= 1'b0;
      end else begin
         if (want.supply_above_sense)
            decay_reg <= 8'h00;
         else if (decay_reg != 8'hff)
            decay_reg <= decay_reg + 8'h01;
         if (adapter_gate_drive && battery_gate_drive)
            shoot <= 1'b1;
      end
   end
   // Supply sags slowly: near the sense node first, below it later
   always_comb begin
      cmp_async = want;
      cmp_async.supply_near_sense = !want.supply_above_sense && decay_reg >= 8'(DECAY);
      cmp_async.supply_above_sense = want.supply_above_sense || decay_reg < 8'(2 * DECAY);
   end
endmodule // ccps_far_side

// file: test/charge_cycle_power_selector_bench.sv
// Self-checking bench for the charge sequencer and power-path selector.
// Assumes the far-side model turns wanted levels into comparator inputs.
`timescale 1ns/1ns
module charge_cycle_power_selector_bench
   import ccps_pkg::*;
;
   localparam int TK = 4;
   localparam int DECAY = 30;
   localparam int SNF = 10 * TK;
   localparam int AD = 6, BT = 5, RUN = 4, FLT = 2, DONE = 1, S8 = 0;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, e, ad, bt, run, pre, flt, done, shoot;
   logic [3:0]  step;
   ccps_cmp_t   want, cmp;
   int          err_total = 0, checks = 0, n;
   wire  [6:0]  o = {ad, bt, run, pre, flt, done, step == 4'h8};
   ccps_top #(.TICK_CYCLES(TK), .PRECHG_TICKS(50), .SAFETY_TICKS_PER_NF(10)) i_ccps_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_async(cmp), .adapter_gate_drive(ad), .battery_gate_drive(bt), .charge_run(run),
      .precharge_current_set(pre), .current_step(step), .status_fault(flt),
      .status_done(done));
   ccps_far_side #(.DECAY(DECAY)) i_ccps_far_side (
      .pclk(pclk), .presetn(presetn), .want(want), .adapter_gate_drive(ad),
      .battery_gate_drive(bt), .cmp_async(cmp), .shoot(shoot));
   initial forever #50 pclk = ~pclk;
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic rng(string nm, int lo, int hi, int got);
      checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask
   task automatic wt(int idx, logic lvl, int lim);
      n = 0;
      while (o[idx] !== lvl && n < lim) begin
         @(negedge pclk);
         n++;
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 20) err_total++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic fin(string nm);
      $display("test %s ended, errors %0d", nm, err_total);
   endtask
   task automatic reallow;
      @(posedge pclk) want.charge_allow <= 1'b0;
      repeat (10) @(negedge pclk);
      @(posedge pclk) want.charge_allow <= 1'b1;
      wt(RUN, 1, 3000);
   endtask
   task automatic term(logic v);
      @(posedge pclk);
      want.cv_phase <= v;
      want.fb_above_recharge <= v;
      want.cur_below_term <= v;
   endtask
   task automatic t_regs;
      chk("battery switch", 1, bt);
      chk("adapter switch", 0, ad);
      apb(0, REG_TCAP, 0);
      chk("tcap", 32'(TCAP_RESET), q);
      apb(0, REG_STAT, 0);
      chk("stat", {14'h0, 4'h8, 4'h0, PWR_BATT, CHG_IDLE}, q);
      apb(1, REG_CTRL, 32'h1);
      apb(0, REG_CTRL, 0);
      chk("ctrl", 1, q);
      apb(1, REG_CTRL, 0);
      apb(1, REG_STAT, 32'hffff_ffff);
      chk("stat write err", 1, e);
      apb(0, 8'h0c, 0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, q);
      fin("regs");
   endtask
   task automatic t_arrive;
      @(posedge pclk) want.supply_above_sense <= 1'b1;
      wt(BT, 0, 2000);
      rng("sleep exit delay", STARTUP_TICKS * TK, STARTUP_TICKS * TK + 16, n);
      chk("adapter in gap", 0, ad);
      wt(AD, 1, 300);
      rng("dead time on", DEAD_CYCLES - 1, DEAD_CYCLES + 1, n);
      chk("battery after", 0, bt);
      fin("arrive");
   endtask
   task automatic t_pre;
      @(posedge pclk);
      want.batt_below_precharge <= 1'b1;
      want.charge_allow <= 1'b1;
      wt(RUN, 1, 40);
      chk("run", 1, run);
      chk("precharge", 1, pre);
      wt(FLT, 1, 400);
      rng("precharge timeout", 50 * TK - 4, 50 * TK + 8, n);
      chk("run stopped", 0, run);
      wt(FLT, 0, 100);
      chk("fault held", 1, flt);
      @(posedge pclk);
      want.batt_below_precharge <= 1'b0;
      want.timer_program_pin_ref <= 1'b1;
      reallow();
      chk("fault cleared", 0, flt);
      chk("fast current", 0, pre);
      chk("first step", 1, step);
      wt(S8, 1, 1000);
      rng("ramp", 7 * STEP_TICKS * TK - 4, 7 * STEP_TICKS * TK + 4, n);
      term(1'b1);
      wt(DONE, 1, 40);
      chk("done", 1, done);
      chk("run at done", 0, run);
      term(1'b0);
      @(posedge pclk) want.batt_below_recharge <= 1'b1;
      wt(RUN, 1, 40);
      chk("recharge", 0, done);
      @(posedge pclk) want.batt_below_recharge <= 1'b0;
      fin("charge");
   endtask
   task automatic t_tmr;
      @(posedge pclk);
      want.timer_program_pin_ref <= 1'b0;
      want.timer_program_pin_low <= 1'b1;
      term(1'b1);
      wt(DONE, 1, 100);
      chk("no done, pin low", 0, done);
      chk("run, pin low", 1, run);
      apb(1, REG_TCAP, 32'h3);
      term(1'b0);
      @(posedge pclk) want.timer_program_pin_low <= 1'b0;
      repeat (40) @(negedge pclk);
      @(posedge pclk) want.battery_overvoltage <= 1'b1;
      repeat (79) @(negedge pclk);
      @(posedge pclk) want.battery_overvoltage <= 1'b0;
      wt(FLT, 1, 400);
      rng("timer rest", 3 * SNF - 44, 3 * SNF - 24, n);
      chk("run at expiry", 0, run);
      @(posedge pclk) want.timer_program_pin_ref <= 1'b1;
      reallow();
      fin("timer");
   endtask
   task automatic t_stop;
      ccps_cmp_t m;
      for (int i = 0; i < 6; i++) begin
         m = '0;
         case (i)
            0: m.die_overtemp_shutdown = 1'b1;
            1: m.pack_temp_fault = 1'b1;
            2: m.driver_regulator_overload = 1'b1;
            3: m.driver_regulator_good = 1'b1;
            4: m.supply_low_state = 1'b1;
            default: m.input_overvoltage = 1'b1;
         endcase
         @(posedge pclk) want <= want ^ m;
         wt(RUN, 0, 40);
         chk("stop", 0, run);
         @(posedge pclk) want <= want ^ m;
         wt(RUN, 1, 3000);
         chk("resume", 1, run);
      end
      apb(1, REG_CTRL, 32'h1);
      wt(RUN, 0, 40);
      chk("inhibit", 0, run);
      apb(1, REG_CTRL, 0);
      @(posedge pclk) want.undervoltage_lockout <= 1'b1;
      wt(BT, 1, 20);
      chk("lockout battery", 1, bt);
      chk("lockout adapter", 0, ad);
      chk("lockout run", 0, run);
      @(posedge pclk) want.undervoltage_lockout <= 1'b0;
      wt(AD, 1, 3000);
      fin("stop");
   endtask
   task automatic t_remove;
      @(posedge pclk) want.supply_above_sense <= 1'b0;
      wt(AD, 0, 200);
      rng("removal wait", DECAY, DECAY + 12, n);
      wt(BT, 1, 300);
      rng("dead time off", DEAD_CYCLES - 1, DEAD_CYCLES + 1, n);
      chk("sleep run", 0, run);
      chk("overlap", 0, shoot);
      fin("remove");
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      want = '0;
      want.driver_regulator_good = 1'b1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      t_regs();
      t_arrive();
      t_pre();
      t_tmr();
      t_stop();
      t_remove();
      wrap_up();
   end
   initial begin
      #(100 * 40000);
      err_total++;
      wrap_up();
   end
endmodule // charge_cycle_power_selector_bench
